// *** rtl/msidec_regs.svh ***
// Field positions, fixed values and reset values of the interrupt message decoder.
`ifndef MSIDEC_REGS_SVH
`define MSIDEC_REGS_SVH

// ----------------------------------------------------------------------------
// Interrupt message address fields
// ----------------------------------------------------------------------------
`define MSIDEC_WIN_HI 31
`define MSIDEC_WIN_LO 20
`define MSIDEC_WIN_VAL 12'hfee
`define MSIDEC_DEST_HI 19
`define MSIDEC_DEST_LO 12
`define MSIDEC_RH_BIT 3
`define MSIDEC_DM_BIT 2

// ----------------------------------------------------------------------------
// Interrupt message payload fields
// ----------------------------------------------------------------------------
`define MSIDEC_VEC_HI 7
`define MSIDEC_VEC_LO 0
`define MSIDEC_DLV_HI 10
`define MSIDEC_DLV_LO 8
`define MSIDEC_LVL_BIT 14
`define MSIDEC_TRIG_BIT 15

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define MSIDEC_ADDR_RST 32'h0000_0000
`define MSIDEC_DATA_RST 32'h0000_0000
`define MSIDEC_VEC_NONE 8'h00
`define MSIDEC_PRIO_MAX 8'hff
`define MSIDEC_ID_BCAST 8'hff

`endif

// *** rtl/msidec_pkg.sv ***
// Types shared by the interrupt message decoder modules.
package msidec_pkg;

   // -------------------------------------------------------------------------
   // Sizes and basic types
   // -------------------------------------------------------------------------
   localparam int MSIDEC_NUM_TGT = 8;

   typedef logic [7:0] msidec_id_t;
   typedef logic [31:0] msidec_word_t;
   typedef logic [MSIDEC_NUM_TGT-1:0] msidec_mask_t;
   typedef logic [MSIDEC_NUM_TGT-1:0][7:0] msidec_idarr_t;

   // -------------------------------------------------------------------------
   // Delivery mode codes
   // -------------------------------------------------------------------------
   typedef enum logic [2:0] {
      MSIDEC_DLV_FIXED = 3'h0,
      MSIDEC_DLV_LOWEST = 3'h1,
      MSIDEC_DLV_SYS_MGMT = 3'h2,
      MSIDEC_DLV_RSVD3 = 3'h3,
      MSIDEC_DLV_NMI = 3'h4,
      MSIDEC_DLV_INIT = 3'h5,
      MSIDEC_DLV_RSVD6 = 3'h6,
      MSIDEC_DLV_EXT_PIC = 3'h7
   } msidec_dlv_e;

endpackage : msidec_pkg

// *** rtl/msidec_target_match.sv ***
// Destination match of one local interrupt controller against a message.
module msidec_target_match
   import msidec_pkg::*;
(
   // Message destination
   input wire msidec_pkg::msidec_id_t dest_id,
   input wire logic logical_sel,
   // Target identity
   input wire msidec_pkg::msidec_id_t phys_id,
   input wire msidec_pkg::msidec_id_t log_id,
   input wire logic cluster_fmt,
   input wire logic enabled,
   // Result
   output logic hit
);
   `include "msidec_regs.svh"

   wire phys_hit;
   wire flat_hit;
   wire cluster_hit;
   wire log_hit;

   // Physical match also accepts the broadcast identifier.
   assign phys_hit = (dest_id == phys_id) || (dest_id == `MSIDEC_ID_BCAST);
   assign flat_hit = |(dest_id & log_id);
   assign cluster_hit = (dest_id[7:4] == log_id[7:4]) && (|(dest_id[3:0] & log_id[3:0]));
   assign log_hit = cluster_fmt ? cluster_hit : flat_hit;
   assign hit = enabled && (logical_sel ? log_hit : phys_hit);

endmodule : msidec_target_match

// *** rtl/msidec_decoder.sv ***
// Interrupt message decoder: splits interrupt writes from memory writes and routes them.
//
// What this block does
// - Address bits 31:20 equal fee mark messages.
// - Writes in window never forwarded as memory.
// - Address carries 8-bit destination identifier.
// - Hint zero delivers to named processor, or to all on broadcast ff unless code 001.
// - Hint one, physical mode: no redirect unless code 001.
// - Hint one, logical mode: redirect within group.
// - Hint zero ignores destination mode bit.
// - Code 000 delivers fixed to all unless hint one in logical mode.
// - Code 001 delivers to lowest priority.
// - Code 010 is management, edge, no vector.
// - Code 100 non-maskable, edge, no vector.
// - Code 101 initialization, edge, no vector.
// - Code 111 drives legacy request, edge.
// - Level bit used only when level triggered.
// - Trigger bit: zero edge, one level.
module msidec_decoder
(
   // Clock and reset
   input wire logic clock,
   input wire logic rstn,
   // Incoming doubleword write
   input wire logic wr_valid,
   input wire msidec_pkg::msidec_word_t wr_addr,
   input wire msidec_pkg::msidec_word_t wr_data,
   // Forwarded ordinary memory write
   output logic fwd_valid,
   output msidec_pkg::msidec_word_t fwd_addr,
   output msidec_pkg::msidec_word_t fwd_data,
   // Local interrupt controller identities
   input wire msidec_pkg::msidec_idarr_t tgt_phys_id,
   input wire msidec_pkg::msidec_idarr_t tgt_log_id,
   input wire msidec_pkg::msidec_mask_t tgt_cluster_fmt,
   input wire msidec_pkg::msidec_mask_t tgt_enabled,
   input wire msidec_pkg::msidec_idarr_t tgt_prio,
   // Delivery to local interrupt controllers
   output logic dlv_valid,
   output msidec_pkg::msidec_mask_t dlv_mask,
   output msidec_pkg::msidec_dlv_e dlv_mode,
   output msidec_pkg::msidec_id_t dlv_vector,
   output logic dlv_level,
   output logic dlv_trig,
   output logic legacy_int_request,
   output logic msg_dropped
);
   import msidec_pkg::*;
   `include "msidec_regs.svh"

   // -------------------------------------------------------------------------
   // Input classification
   // -------------------------------------------------------------------------
   wire in_window;
   wire take_msg;
   wire take_fwd;

   assign in_window = (wr_addr[`MSIDEC_WIN_HI:`MSIDEC_WIN_LO] == `MSIDEC_WIN_VAL);
   assign take_msg = wr_valid && in_window;
   assign take_fwd = wr_valid && !in_window;

   // -------------------------------------------------------------------------
   // Captured message address and payload
   // -------------------------------------------------------------------------
   msidec_word_t msg_addr_q;
   msidec_word_t msg_addr_d;
   msidec_word_t msg_data_q;
   msidec_word_t msg_data_d;
   logic pend_q;
   msidec_word_t fwd_addr_q;
   msidec_word_t fwd_data_q;
   logic fwd_valid_q;

   assign msg_addr_d = take_msg ? wr_addr : msg_addr_q;
   assign msg_data_d = take_msg ? wr_data : msg_data_q;

   always_ff @(posedge clock)
   begin
      if (!rstn)
      begin
         msg_addr_q <= `MSIDEC_ADDR_RST;
         msg_data_q <= `MSIDEC_DATA_RST;
         pend_q <= 1'b0;
         fwd_valid_q <= 1'b0;
         fwd_addr_q <= `MSIDEC_ADDR_RST;
         fwd_data_q <= `MSIDEC_DATA_RST;
      end
      else
      begin
         msg_addr_q <= msg_addr_d;
         msg_data_q <= msg_data_d;
         pend_q <= take_msg;
         fwd_valid_q <= take_fwd;
         fwd_addr_q <= take_fwd ? wr_addr : fwd_addr_q;
         fwd_data_q <= take_fwd ? wr_data : fwd_data_q;
      end
   end

   assign fwd_valid = fwd_valid_q;
   assign fwd_addr = fwd_addr_q;
   assign fwd_data = fwd_data_q;

   // -------------------------------------------------------------------------
   // Field extraction
   // -------------------------------------------------------------------------
   msidec_id_t dest_id;
   wire redirect_hint;
   wire dest_mode_sel;
   wire logical_sel;
   msidec_id_t vec_in;
   msidec_dlv_e mode_in;
   wire lvl_in;
   wire trig_in;

   assign dest_id = msg_addr_q[`MSIDEC_DEST_HI:`MSIDEC_DEST_LO];
   assign redirect_hint = msg_addr_q[`MSIDEC_RH_BIT];
   assign dest_mode_sel = msg_addr_q[`MSIDEC_DM_BIT];
   // Without the hint the mode bit is ignored and the identifier is taken as physical.
   assign logical_sel = redirect_hint && dest_mode_sel;
   assign vec_in = msg_data_q[`MSIDEC_VEC_HI:`MSIDEC_VEC_LO];
   assign mode_in = msidec_dlv_e'(msg_data_q[`MSIDEC_DLV_HI:`MSIDEC_DLV_LO]);
   assign lvl_in = msg_data_q[`MSIDEC_LVL_BIT];
   assign trig_in = msg_data_q[`MSIDEC_TRIG_BIT];

   // -------------------------------------------------------------------------
   // Per-target match and lowest priority search
   // -------------------------------------------------------------------------
   msidec_mask_t hit;
   logic [MSIDEC_NUM_TGT:0] found;
   logic [MSIDEC_NUM_TGT:0][7:0] best_pri;
   logic [MSIDEC_NUM_TGT:0][MSIDEC_NUM_TGT-1:0] best_sel;
   msidec_mask_t take;
   localparam msidec_mask_t UNIT = 8'h01;

   assign found[0] = 1'b0;
   assign best_pri[0] = `MSIDEC_PRIO_MAX;
   assign best_sel[0] = 8'h00;

   genvar g;
   generate
      for (g = 0; g < MSIDEC_NUM_TGT; g = g + 1)
      begin : g_tgt
         msidec_target_match u_match (
            .dest_id(dest_id),
            .logical_sel(logical_sel),
            .phys_id(tgt_phys_id[g]),
            .log_id(tgt_log_id[g]),
            .cluster_fmt(tgt_cluster_fmt[g]),
            .enabled(tgt_enabled[g]),
            .hit(hit[g])
         );
         // Ties go to the lowest numbered target.
         assign take[g] = hit[g] && (!found[g] || (tgt_prio[g] < best_pri[g]));
         assign found[g+1] = found[g] || hit[g];
         assign best_pri[g+1] = take[g] ? tgt_prio[g] : best_pri[g];
         assign best_sel[g+1] = take[g] ? (UNIT << g) : best_sel[g];
      end
   endgenerate

   // -------------------------------------------------------------------------
   // Delivery decision
   // -------------------------------------------------------------------------
   wire mode_rsvd;
   wire use_lowest;
   wire vec_used;
   wire lvl_allowed;
   wire trig_eff;
   msidec_mask_t mask_eff;
   msidec_id_t vec_eff;
   wire lvl_eff;
   wire deliver;

   assign mode_rsvd = (mode_in == MSIDEC_DLV_RSVD3) || (mode_in == MSIDEC_DLV_RSVD6);
   // Physical mode with the hint set redirects only for code 001; otherwise every matching target, broadcast included, gets it.
   assign use_lowest = (mode_in == MSIDEC_DLV_LOWEST) || logical_sel;
   assign mask_eff = use_lowest ? best_sel[MSIDEC_NUM_TGT] : hit;
   assign vec_used = (mode_in == MSIDEC_DLV_FIXED) || (mode_in == MSIDEC_DLV_LOWEST);
   // Management, non-maskable, init and legacy deliveries drop the vector.
   assign vec_eff = vec_used ? vec_in : `MSIDEC_VEC_NONE;
   // Only fixed and lowest priority deliveries may be level sensitive.
   assign lvl_allowed = vec_used;
   assign trig_eff = lvl_allowed && trig_in;
   // Edge messages are always asserts.
   assign lvl_eff = trig_eff ? lvl_in : 1'b1;
   assign deliver = pend_q && !mode_rsvd && (|mask_eff);

   logic dlv_valid_q;
   msidec_mask_t dlv_mask_q;
   msidec_dlv_e dlv_mode_q;
   msidec_id_t dlv_vector_q;
   logic dlv_level_q;
   logic dlv_trig_q;
   logic drop_q;

   always_ff @(posedge clock)
   begin
      if (!rstn)
      begin
         dlv_valid_q <= 1'b0;
         dlv_mask_q <= 8'h00;
         dlv_mode_q <= MSIDEC_DLV_FIXED;
         dlv_vector_q <= `MSIDEC_VEC_NONE;
         dlv_level_q <= 1'b0;
         dlv_trig_q <= 1'b0;
         drop_q <= 1'b0;
      end
      else
      begin
         dlv_valid_q <= deliver;
         dlv_mask_q <= deliver ? mask_eff : 8'h00;
         dlv_mode_q <= deliver ? mode_in : dlv_mode_q;
         dlv_vector_q <= deliver ? vec_eff : dlv_vector_q;
         dlv_level_q <= deliver ? lvl_eff : dlv_level_q;
         dlv_trig_q <= deliver ? trig_eff : dlv_trig_q;
         drop_q <= pend_q && !deliver;
      end
   end

   assign dlv_valid = dlv_valid_q;
   assign dlv_mask = dlv_mask_q;
   assign dlv_mode = dlv_mode_q;
   assign dlv_vector = dlv_vector_q;
   assign dlv_level = dlv_level_q;
   assign dlv_trig = dlv_trig_q;
   assign legacy_int_request = dlv_valid_q && (dlv_mode_q == MSIDEC_DLV_EXT_PIC);
   assign msg_dropped = drop_q;

   // -------------------------------------------------------------------------
   // Assertions
   // -------------------------------------------------------------------------
   a_plain_forward: assert property (@(posedge clock) disable iff (!rstn)
      wr_valid && (wr_addr[31:20] != 12'hfee)
      |=> fwd_valid && (fwd_addr == $past(wr_addr)) && (fwd_data == $past(wr_data)))
      else $error("ordinary write not forwarded");

   a_window_no_fwd: assert property (@(posedge clock) disable iff (!rstn)
      wr_valid && (wr_addr[31:20] == 12'hfee) |=> !fwd_valid)
      else $error("interrupt write forwarded as memory");

   a_reserved_drop: assert property (@(posedge clock) disable iff (!rstn)
      take_msg && ((wr_data[10:8] == 3'h3) || (wr_data[10:8] == 3'h6))
      |=> ##1 !dlv_valid && msg_dropped)
      else $error("reserved delivery code delivered");

   a_nmi_edge_novec: assert property (@(posedge clock) disable iff (!rstn)
      dlv_valid && (dlv_mode == MSIDEC_DLV_NMI) |-> !dlv_trig && (dlv_vector == 8'h00))
      else $error("non-maskable delivery not edge or vector kept");

   a_init_edge_novec: assert property (@(posedge clock) disable iff (!rstn)
      dlv_valid && (dlv_mode == MSIDEC_DLV_INIT) |-> !dlv_trig && (dlv_vector == 8'h00))
      else $error("init delivery not edge or vector kept");

   a_legacy_request: assert property (@(posedge clock) disable iff (!rstn)
      take_msg && (wr_data[10:8] == 3'h7) && !wr_addr[3] && (wr_addr[19:12] == tgt_phys_id[0])
      && tgt_enabled[0] |=> ##1 legacy_int_request && !dlv_trig && dlv_mask[0])
      else $error("legacy request not raised");

   a_edge_asserts: assert property (@(posedge clock) disable iff (!rstn)
      dlv_valid && !dlv_trig |-> dlv_level)
      else $error("edge message not an assert");

   a_level_follows: assert property (@(posedge clock) disable iff (!rstn)
      take_msg && (wr_data[10:8] == 3'h0) && wr_data[15] && !wr_addr[3]
      ##1 deliver |=> dlv_trig && (dlv_level == $past(msg_data_q[14])))
      else $error("level message lost its level");

   a_lowest_single: assert property (@(posedge clock) disable iff (!rstn)
      dlv_valid && (dlv_mode == MSIDEC_DLV_LOWEST) |-> $onehot(dlv_mask))
      else $error("lowest priority hit several targets");

   a_phys_no_redir: assert property (@(posedge clock) disable iff (!rstn)
      pend_q && redirect_hint && !dest_mode_sel && (dest_id != 8'hff) && (mode_in == 3'h0)
      |=> dlv_mask == $past(hit))
      else $error("physical hinted message redirected");

   a_fixed_all: assert property (@(posedge clock) disable iff (!rstn)
      pend_q && (mode_in == 3'h0) && !redirect_hint && (|hit) |=> dlv_valid && (dlv_mask == $past(hit)))
      else $error("fixed delivery missed a target");

   a_mgmt_edge_novec: assert property (@(posedge clock) disable iff (!rstn)
      dlv_valid && (dlv_mode == MSIDEC_DLV_SYS_MGMT) |-> !dlv_trig && (dlv_vector == 8'h00))
      else $error("management delivery not edge or vector kept");

   a_legacy_novec: assert property (@(posedge clock) disable iff (!rstn)
      dlv_valid && (dlv_mode == MSIDEC_DLV_EXT_PIC) |-> !dlv_trig && (dlv_vector == 8'h00))
      else $error("legacy delivery not edge or vector kept");

   a_hint_off_phys: assert property (@(posedge clock) disable iff (!rstn)
      pend_q && !redirect_hint && (mode_in == MSIDEC_DLV_FIXED) && tgt_enabled[1]
      && (dest_id == tgt_phys_id[1]) |=> dlv_valid && dlv_mask[1])
      else $error("unhinted message missed its physical target");

   a_logical_group: assert property (@(posedge clock) disable iff (!rstn)
      pend_q && redirect_hint && dest_mode_sel && !mode_rsvd && (|hit)
      |=> dlv_valid && $onehot(dlv_mask) && ((dlv_mask & $past(hit)) == dlv_mask))
      else $error("redirection left the logical group");

   a_mask_idle_zero: assert property (@(posedge clock) disable iff (!rstn)
      !dlv_valid |-> (dlv_mask == 8'h00))
      else $error("target mask shown without delivery");

endmodule : msidec_decoder

// *** test/msidec_lic_model.sv ***
// Behavioural model of the eight local interrupt controllers behind the decoder.
module msidec_lic_model
#(
   parameter msidec_pkg::msidec_id_t PHYS_BASE = 8'h10
)
(
   // Configuration from the bench
   input wire msidec_pkg::msidec_mask_t cfg_en,
   input wire msidec_pkg::msidec_idarr_t cfg_prio,
   input wire logic cfg_clu,
   // Identities seen by the decoder
   output msidec_pkg::msidec_idarr_t tgt_phys_id,
   output msidec_pkg::msidec_idarr_t tgt_log_id,
   output msidec_pkg::msidec_mask_t tgt_cluster_fmt,
   output msidec_pkg::msidec_mask_t tgt_enabled,
   output msidec_pkg::msidec_idarr_t tgt_prio
);
   timeunit 1ns;
   timeprecision 1ps;
   import msidec_pkg::*;

   // Flat format: each controller owns one bit; cluster format: two clusters of four.
   for (genvar i = 0; i < MSIDEC_NUM_TGT; i++)
   begin : g_tgt
      assign tgt_phys_id[i] = PHYS_BASE + 8'(i);
      assign tgt_log_id[i] = cfg_clu ? {4'(i / 4), 4'h1 << (i % 4)} : 8'h01 << i;
   end
   assign tgt_cluster_fmt = {8{cfg_clu}};
   assign tgt_enabled = cfg_en;
   assign tgt_prio = cfg_prio;
endmodule : msidec_lic_model

// *** test/tb_msi_message_decoder.sv ***
// Self-checking bench of the interrupt message decoder with random and corner-case writes.
module tb_msi_message_decoder;
   timeunit 1ns;
   timeprecision 1ps;
   import msidec_pkg::*;

   // ------------------------------------------------------------------------
   // Signals and expectations
   // ------------------------------------------------------------------------
   localparam msidec_id_t PHYS_BASE = 8'h10;
   typedef struct packed {
      logic valid;
      logic drop;
      msidec_mask_t mask;
      logic [2:0] mode;
      msidec_id_t vec;
      logic lvl;
      logic trig;
   } msidec_exp_s;
   logic clock = 1'b0;
   logic rstn = 1'b0;
   logic wr_valid = 1'b0;
   msidec_word_t wr_addr = '0;
   msidec_word_t wr_data = '0;
   msidec_mask_t cfg_en = 8'hff;
   msidec_idarr_t cfg_prio = '0;
   logic cfg_clu = 1'b0;
   logic fwd_valid, dlv_valid, dlv_level, dlv_trig, legacy_int_request, msg_dropped;
   msidec_word_t fwd_addr, fwd_data;
   msidec_mask_t dlv_mask, tgt_cluster_fmt, tgt_enabled;
   msidec_dlv_e dlv_mode;
   msidec_id_t dlv_vector;
   msidec_idarr_t tgt_phys_id, tgt_log_id, tgt_prio;
   int err_total = 0, num_checks = 0, seed = 37, cycles = 0;
   msidec_exp_s m1 = '0, m2 = '0;
   logic f1v = 1'b0;
   msidec_word_t f1a = '0, f1d = '0;
   msidec_word_t edge_addr [5] = '{32'hfed0_0000, 32'hfeef_fff0, 32'hfef0_0000, 32'h0, '1};

   msidec_decoder msidec_decoder_inst (.clock(clock), .rstn(rstn), .wr_valid(wr_valid),
      .wr_addr(wr_addr), .wr_data(wr_data), .fwd_valid(fwd_valid), .fwd_addr(fwd_addr),
      .fwd_data(fwd_data), .tgt_phys_id(tgt_phys_id), .tgt_log_id(tgt_log_id),
      .tgt_cluster_fmt(tgt_cluster_fmt), .tgt_enabled(tgt_enabled), .tgt_prio(tgt_prio),
      .dlv_valid(dlv_valid), .dlv_mask(dlv_mask), .dlv_mode(dlv_mode),
      .dlv_vector(dlv_vector), .dlv_level(dlv_level), .dlv_trig(dlv_trig),
      .legacy_int_request(legacy_int_request), .msg_dropped(msg_dropped));
   msidec_lic_model #(.PHYS_BASE(PHYS_BASE)) msidec_lic_model_inst (.cfg_en(cfg_en),
      .cfg_prio(cfg_prio), .cfg_clu(cfg_clu), .tgt_phys_id(tgt_phys_id), .tgt_log_id(tgt_log_id),
      .tgt_cluster_fmt(tgt_cluster_fmt), .tgt_enabled(tgt_enabled), .tgt_prio(tgt_prio));

   // ------------------------------------------------------------------------
   // Tasks and functions
   // ------------------------------------------------------------------------
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp)
      begin
         err_total++;
         $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   task automatic summarize();
      $display("checks %0d mismatches %0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : summarize

   function automatic msidec_exp_s expect_msg(input msidec_word_t a, input msidec_word_t d);
      msidec_exp_s e;
      msidec_id_t ds;
      logic [2:0] c;
      int best;
      ds = a[19:12];
      c = d[10:8];
      e = '0;
      best = -1;
      for (int i = 0; i < 8; i++)
         if (a[3] && a[2])
            e.mask[i] = cfg_en[i] && (cfg_clu ? (ds[7:4] == 4'(i / 4) && ds[i % 4]) : ds[i]);
         else
            e.mask[i] = cfg_en[i] && (ds == PHYS_BASE + 8'(i) || ds == 8'hff);
      // Lowest priority wins, ties go to the lowest index.
      if (c == 3'h1 || (a[3] && a[2]))
      begin
         for (int i = 0; i < 8; i++)
            if (e.mask[i] && (best < 0 || cfg_prio[i] < cfg_prio[best]))
               best = i;
         if (best >= 0)
            e.mask = 8'h01 << best;
      end
      e.mode = c;
      e.vec = (c < 3'h2) ? d[7:0] : 8'h00;
      e.trig = (c < 3'h2) && d[15];
      e.lvl = e.trig ? d[14] : 1'b1;
      e.drop = (c == 3'h3 || c == 3'h6 || e.mask == '0);
      e.valid = !e.drop;
      return e;
   endfunction : expect_msg

   task automatic wr(input msidec_word_t a, input msidec_word_t d);
      @(posedge clock);
      wr_valid <= 1'b1;
      wr_addr <= a;
      wr_data <= d;
   endtask : wr

   task automatic idle(input int n);
      repeat (n)
      begin
         @(posedge clock);
         wr_valid <= 1'b0;
         wr_addr <= $random(seed);
      end
   endtask : idle

   task automatic send_msg(input logic [2:0] c, input logic rh, input logic dm);
      msidec_word_t r, d;
      msidec_id_t ds;
      logic [2:0] idx;
      logic [3:0] grp;
      r = $random(seed);
      idx = r[2:0];
      repeat (8)
         if (!cfg_en[idx])
            idx++;
      grp = idx[2] ? cfg_en[7:4] : cfg_en[3:0];
      if (rh && dm && cfg_clu)
         ds = {4'(idx[2]), (r[27:24] | (4'h1 << idx[1:0])) & grp};
      else if (rh && dm)
         ds = r[31:24] & cfg_en & 8'h7f;
      else if (rh || r[4:3] == 2'h0)
         ds = PHYS_BASE + 8'(idx);
      else
         ds = (r[4:3] == 2'h1) ? 8'hff : 8'h55;
      if (ds == 8'h00)
         ds = cfg_en & 8'h7f;
      d = $random(seed);
      d[10:8] = c;
      d[7:0] = (c < 3'h2) ? 8'h10 + d[7:0] % 8'hef : (c == 3'h2 ? 8'h00 : d[7:0]);
      d[15] = d[15] && (c < 3'h2 || c == 3'h4 || c == 3'h5);
      wr({12'hfee, ds, r[15:8], rh, dm, r[17:16]}, d);
   endtask : send_msg

   // ------------------------------------------------------------------------
   // Clock, monitor and timeout
   // ------------------------------------------------------------------------
   initial
   begin
      forever #10 clock = ~clock;
   end

   // Inputs seen at a falling edge are taken at the next rising edge.
   always @(negedge clock)
   begin
      check(32'(fwd_valid), 32'(f1v));
      if (f1v)
         check((fwd_addr ^ f1a) | (fwd_data ^ f1d), 32'h0);
      check(32'(dlv_valid), 32'(m2.valid));
      check(32'(msg_dropped), 32'(m2.drop));
      check(32'(legacy_int_request), 32'(m2.valid && m2.mode == 3'h7));
      if (m2.valid)
      begin
         check(32'(dlv_mask), 32'(m2.mask));
         check(32'(dlv_mode), 32'(m2.mode));
         check(32'(dlv_vector), 32'(m2.vec));
         check(32'({dlv_level, dlv_trig}), 32'({m2.lvl, m2.trig}));
      end
      m2 = rstn ? m1 : '0;
      m1 = (rstn && wr_valid && wr_addr[31:20] == 12'hfee) ? expect_msg(wr_addr, wr_data) : '0;
      f1v = rstn && wr_valid && wr_addr[31:20] != 12'hfee;
      f1a = wr_addr;
      f1d = wr_data;
   end

   always @(posedge clock)
   begin
      cycles++;
      if (cycles == 3000)
      begin
         err_total++;
         summarize();
      end
   end

   // ------------------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------------------
   initial
   begin
      msidec_word_t r;
      repeat (8) @(posedge clock);
      rstn <= 1'b1;
      @(negedge clock);
      check(32'({dlv_mask, dlv_mode, dlv_vector, dlv_level, dlv_trig}), 32'h0);
      check(fwd_addr | fwd_data, 32'h0);
      for (int c = 0; c < 8; c++)
         for (int h = 0; h < 4; h++)
            send_msg(3'(c), h[1], h[0]);
      foreach (edge_addr[k])
         wr(edge_addr[k], $random(seed));
      send_msg(3'h0, 1'b0, 1'b1);
      @(posedge clock);
      rstn <= 1'b0;
      wr_valid <= 1'b0;
      @(posedge clock);
      rstn <= 1'b1;
      @(negedge clock);
      check(32'({dlv_mask, dlv_mode, dlv_vector, dlv_level, dlv_trig}), 32'h0);
      check(fwd_addr | fwd_data, 32'h0);
      repeat (8)
      begin
         idle(3);
         cfg_en <= 8'($random(seed)) | 8'h01;
         cfg_clu <= 1'($random(seed));
         cfg_prio <= {$random(seed), $random(seed)} & {8{8'h03}};
         repeat (40)
         begin
            r = $random(seed);
            if (r[2:0] == 3'h0)
               wr(r, $random(seed));
            else
               send_msg(r[10:8], r[11], r[12]);
            if (r[13])
               idle(1);
         end
      end
      idle(4);
      summarize();
   end
endmodule : tb_msi_message_decoder
